// ===== include/rmp_map.vh
`ifndef RMP_MAP_VH
`define RMP_MAP_VH

// Register byte addresses
`define RMP_ADDR_ROM_MAP 12'h034
`define RMP_ADDR_FAIL_LO 12'h038
`define RMP_ADDR_FAIL_HI 12'h03c
`define RMP_ADDR_VENDOR 12'h040
`define RMP_ADDR_CTRL 12'h080
`define RMP_ADDR_INT_STAT 12'h084
`define RMP_ADDR_INT_CLR 12'h088
`define RMP_ADDR_INT_EN 12'h08c

// ROM map field
`define RMP_ROM_BASE_LSB 10
`define RMP_ROM_LOW_BITS 10
`define RMP_ROM_MAP_RESET 32'h00000000

// Configuration ROM window on the serial bus
`define RMP_ROM_WIN_LO 48'hfffff0000400
`define RMP_ROM_WIN_HI 48'hfffff00007ff

// Control register fields
`define RMP_CTRL_POST_BIT 18
`define RMP_CTRL_RESET 32'h00000000

// Interrupt status bits
`define RMP_INT_FAIL 0
`define RMP_INT_ROMRD 1
`define RMP_INT_REFUSED 2
`define RMP_INT_W 3

// Failure register layout
`define RMP_HI_OFFS_W 16
`define RMP_SRC_W 16

`endif

// ===== hdl/rmp_rom_xlate.v
`timescale 1ns/10ps
`include "rmp_map.vh"

module rmp_rom_xlate #(
    parameter AW = 32
) (
    input wire pclk, // Clock
    input wire presetn, // Async reset, low
    input wire rd_valid, // Quadlet read request strobe
    input wire [47:0] rd_offset, // Serial bus offset
    input wire [AW-1:0] base, // ROM map register value
    output reg hit_q, // Redirect pulse
    output reg [AW-1:0] host_addr_q // Host memory address
);

    wire in_win;
    wire [AW-1:0] low_ext;

    assign in_win = (rd_offset >= `RMP_ROM_WIN_LO) && (rd_offset <= `RMP_ROM_WIN_HI);
    assign low_ext = {{(AW-`RMP_ROM_LOW_BITS){1'b0}}, rd_offset[`RMP_ROM_LOW_BITS-1:0]};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q <= 1'b0;
            host_addr_q <= {AW{1'b0}};
        end else begin
            hit_q <= rd_valid && in_win;
            if (rd_valid && in_win) begin
                host_addr_q <= base + low_ext;
            end
        end
    end

endmodule // rmp_rom_xlate

// ===== hdl/rmp_fail_capture.v
`timescale 1ns/10ps
`include "rmp_map.vh"

module rmp_fail_capture (
    input wire pclk, // Clock
    input wire presetn, // Async reset, low
    input wire fail_valid, // Posted write failure strobe
    input wire [47:0] fail_offset, // Destination offset of failed write
    input wire [15:0] fail_source, // Bus and node number of requester
    output reg [31:0] fail_lo_q, // Low failure register
    output reg [31:0] fail_hi_q // High failure register
);

    // Contents undefined until first failure; cleared for determinism
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_lo_q <= 32'h00000000;
            fail_hi_q <= 32'h00000000;
        end else if (fail_valid) begin
            fail_lo_q <= fail_offset[31:0];
            fail_hi_q <= {fail_source, fail_offset[47:32]};
        end
    end

endmodule // rmp_fail_capture

// ===== hdl/rmp_regs.v
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "rmp_map.vh"

module rmp_regs #(
    parameter VENDOR_IDENTITY = 32'h0a1b2c3d // Arbitrary value
) (
    input wire pclk, // Clock
    input wire presetn, // Async reset, low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error
    input wire rd_valid, // Incoming quadlet read strobe
    input wire [47:0] rd_offset, // Incoming read offset
    output wire rom_hit, // ROM read redirected pulse
    output wire [31:0] rom_host_addr, // Host memory address
    input wire wr_valid, // Incoming write request strobe
    output wire wr_posted, // Write accepted as posted
    input wire fail_valid, // Posted data write failed strobe
    input wire [47:0] fail_offset, // Failed write offset
    input wire [15:0] fail_source, // Failed write source node
    output wire irq // Interrupt, high active level
);

    reg [31:0] rom_map_q;
    reg [31:0] ctrl_q;
    reg [`RMP_INT_W-1:0] int_stat_q;
    reg [`RMP_INT_W-1:0] int_stat_d;
    reg [`RMP_INT_W-1:0] int_en_q;
    wire [31:0] fail_lo;
    wire [31:0] fail_hi;
    wire wr_en;
    wire rd_en;
    wire posted_write_allow;
    wire [`RMP_INT_W-1:0] events;
    wire [`RMP_INT_W-1:0] clr;
    reg [31:0] rdata_d;
    reg mapped;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `RMP_ADDR_ROM_MAP) || (a == `RMP_ADDR_FAIL_LO) ||
                (a == `RMP_ADDR_FAIL_HI) || (a == `RMP_ADDR_VENDOR) ||
                (a == `RMP_ADDR_CTRL) || (a == `RMP_ADDR_INT_STAT) ||
                (a == `RMP_ADDR_INT_CLR) || (a == `RMP_ADDR_INT_EN);
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign posted_write_allow = ctrl_q[`RMP_CTRL_POST_BIT];
    assign wr_posted = wr_valid && posted_write_allow;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_map_q <= `RMP_ROM_MAP_RESET;
            ctrl_q <= `RMP_CTRL_RESET;
            int_en_q <= {`RMP_INT_W{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `RMP_ADDR_ROM_MAP: begin
                    rom_map_q <= {pwdata[31:`RMP_ROM_BASE_LSB], {`RMP_ROM_BASE_LSB{1'b0}}};
                end
                `RMP_ADDR_CTRL: begin
                    ctrl_q <= pwdata & (32'h00000001 << `RMP_CTRL_POST_BIT);
                end
                `RMP_ADDR_INT_EN: begin
                    int_en_q <= pwdata[`RMP_INT_W-1:0];
                end
                default: begin
                    // Vendor and failure registers ignore writes
                    rom_map_q <= rom_map_q;
                end
            endcase
        end
    end

    rmp_rom_xlate #(
        .AW(32)
    ) u_xlate (
        .pclk(pclk),
        .presetn(presetn),
        .rd_valid(rd_valid),
        .rd_offset(rd_offset),
        .base(rom_map_q),
        .hit_q(rom_hit),
        .host_addr_q(rom_host_addr)
    );

    rmp_fail_capture u_fail (
        .pclk(pclk),
        .presetn(presetn),
        .fail_valid(fail_valid),
        .fail_offset(fail_offset),
        .fail_source(fail_source),
        .fail_lo_q(fail_lo),
        .fail_hi_q(fail_hi)
    );

    // Event bits: failure, ROM redirect, refused post
    assign events[`RMP_INT_FAIL] = fail_valid;
    assign events[`RMP_INT_ROMRD] = rom_hit;
    assign events[`RMP_INT_REFUSED] = wr_valid && !posted_write_allow;
    assign clr = (wr_en && (paddr == `RMP_ADDR_INT_CLR)) ? pwdata[`RMP_INT_W-1:0] : {`RMP_INT_W{1'b0}};

    // Set wins over clear
    always @* begin
        int_stat_d = (int_stat_q & ~clr) | events;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= {`RMP_INT_W{1'b0}};
        end else begin
            int_stat_q <= int_stat_d;
        end
    end

    assign irq = |(int_stat_q & int_en_q);

    always @* begin
        rdata_d = 32'h00000000;
        mapped = 1'b1;
        case (paddr)
            `RMP_ADDR_ROM_MAP: rdata_d = {rom_map_q[31:`RMP_ROM_BASE_LSB], {`RMP_ROM_BASE_LSB{1'b0}}};
            `RMP_ADDR_FAIL_LO: rdata_d = fail_lo;
            `RMP_ADDR_FAIL_HI: rdata_d = fail_hi;
            `RMP_ADDR_VENDOR: rdata_d = VENDOR_IDENTITY;
            `RMP_ADDR_CTRL: rdata_d = ctrl_q;
            `RMP_ADDR_INT_STAT: rdata_d = {{(32-`RMP_INT_W){1'b0}}, int_stat_q};
            `RMP_ADDR_INT_EN: rdata_d = {{(32-`RMP_INT_W){1'b0}}, int_en_q};
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in setup cycle, valid in access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= mapped ? rdata_d : 32'h00000000;
        end
    end

endmodule // rmp_regs

// ===== sim/rmp_regs_asserts.sv
`timescale 1ns/10ps
module rmp_chk #(parameter VENDOR_IDENTITY = 32'h0a1b2c3d) ( // Arbitrary value
    input wire pclk, presetn, psel, penable, pwrite, // Clock, reset, bus
    input wire [31:0] pwdata, // Write data
    input wire [11:0] paddr, // Address
    input wire [31:0] prdata, rom_host_addr, // Read data, host address
    input wire rd_valid, rom_hit, wr_valid, wr_posted, fail_valid, // Strobes
    input wire [47:0] rd_offset, fail_offset, // Offsets
    input wire [15:0] fail_source // Source node
);
    logic [47:0] off_q;
    logic [15:0] src_q;
    logic allow_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) allow_q <= 1'b0;
        else if (psel && penable && pwrite && paddr == 12'h080) allow_q <= pwdata[18];
    end
    wire rd_acc = psel && penable && !pwrite;
    wire in_win = rd_offset >= 48'hfffff0000400 && rd_offset <= 48'hfffff00007ff;
    wire [9:0] rd_low = rd_offset[9:0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) {off_q, src_q} <= 64'h0;
        else if (fail_valid) {off_q, src_q} <= {fail_offset, fail_source};
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_hit_window: assert property (rd_valid && in_win |=> rom_hit) else $error("no redirect");
    chk_miss_quiet: assert property (rd_valid && !in_win |=> !rom_hit) else $error("bad redirect");
    chk_host_low: assert property (rom_hit |-> rom_host_addr[9:0] == $past(rd_low)) else $error("host addr");
    chk_rom_low: assert property (rd_acc && paddr == 12'h034 |-> prdata[9:0] == 10'h000) else $error("low");
    chk_vendor_fixed: assert property (rd_acc && paddr == 12'h040 |-> prdata == VENDOR_IDENTITY) else $error("id");
    chk_fail_low: assert property (rd_acc && paddr == 12'h038 |-> prdata == off_q[31:0]) else $error("lo");
    chk_fail_high: assert property (rd_acc && paddr == 12'h03c |-> prdata == {src_q, off_q[47:32]})
        else $error("hi");
    chk_post_gate: assert property (wr_posted == (wr_valid && allow_q)) else $error("posted");
endmodule // rmp_chk
bind rmp_regs rmp_chk #(.VENDOR_IDENTITY(VENDOR_IDENTITY)) chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .paddr(paddr), .prdata(prdata), .rom_host_addr(rom_host_addr),
    .rd_valid(rd_valid),
    .rom_hit(rom_hit), .wr_valid(wr_valid), .wr_posted(wr_posted), .fail_valid(fail_valid),
    .rd_offset(rd_offset), .fail_offset(fail_offset), .fail_source(fail_source));

// ===== sim/rmp_node_model.sv
`timescale 1ns/10ps
module rmp_node_model (
    input wire pclk, wr_posted, // Clock, posting answer
    output logic rd_valid = 1'b0, wr_valid = 1'b0, fail_valid = 1'b0, // Strobes
    output logic [47:0] rd_offset = 48'h0, fail_offset = 48'h0, // Offsets
    output logic [15:0] fail_source = 16'h0 // Source node
);
    task quad_read(input logic [47:0] o);
        @(posedge pclk);
        {rd_valid, rd_offset} <= {1'b1, o};
        @(posedge pclk);
        {rd_valid, rd_offset} <= {1'b0, ~o}; // Released lines drop the old offset
    endtask
    task post_write(output logic p);
        @(posedge pclk);
        wr_valid <= 1'b1;
        #1 p = wr_posted;
        @(posedge pclk);
        wr_valid <= 1'b0;
    endtask
    task write_fail(input logic [47:0] o, input logic [15:0] s);
        @(posedge pclk);
        {fail_valid, fail_offset, fail_source} <= {1'b1, o, s};
        @(posedge pclk);
        {fail_valid, fail_offset, fail_source} <= {1'b0, ~o, ~s};
    endtask
endmodule // rmp_node_model

// ===== sim/rom_map_posted_write_error_regs_bench.sv
`timescale 1ns/10ps
module rom_map_posted_write_error_regs_bench;
    localparam logic [31:0] VEND = 32'h5a5a0001; // Arbitrary value
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, p;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [47:0] offs [4] = '{48'hfffff0000400, 48'hfffff00007ff, 48'hfffff00003ff, 48'hfffff0000800};
    wire pready, pslverr, rom_hit, wr_valid, wr_posted, rd_valid, fail_valid, irq;
    wire [31:0] prdata, rom_host_addr;
    wire [47:0] rd_offset, fail_offset;
    wire [15:0] fail_source;
    int mismatches = 0, num_checks = 0;
    always #2.5 pclk = ~pclk;
    rmp_regs #(.VENDOR_IDENTITY(VEND)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rd_valid(rd_valid), .rd_offset(rd_offset), .rom_hit(rom_hit), .rom_host_addr(rom_host_addr),
        .wr_valid(wr_valid), .wr_posted(wr_posted), .fail_valid(fail_valid), .fail_offset(fail_offset),
        .fail_source(fail_source), .irq(irq));
    rmp_node_model node (.pclk(pclk), .wr_posted(wr_posted), .rd_valid(rd_valid), .wr_valid(wr_valid),
        .fail_valid(fail_valid), .rd_offset(rd_offset), .fail_offset(fail_offset), .fail_source(fail_source));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task t_regs;
        apb(0, 12'h034, 0);
        chk(rd, 32'h0);
        apb(1, 12'h034, 32'hffffffff);
        apb(0, 12'h034, 0);
        chk(rd, 32'hfffffc00);
        apb(1, 12'h040, 32'hffffffff);
        apb(0, 12'h040, 0);
        chk(rd, VEND);
        apb(0, 12'h0f0, 0);
        chk({31'h0, err}, 32'h1);
    endtask
    task t_rom;
        apb(1, 12'h034, 32'h12345c00);
        for (int i = 0; i < 4; i++) begin
            node.quad_read(offs[i]);
            #1 chk({31'h0, rom_hit}, i < 2);
            if (i < 2) chk(rom_host_addr, 32'h12345c00 + offs[i][9:0]);
        end
        chk({31'h0, irq}, 32'h0);
        apb(1, 12'h08c, 32'h2);
        #1 chk({31'h0, irq}, 32'h1);
        apb(1, 12'h088, 32'h2);
        #1 chk({31'h0, irq}, 32'h0);
    endtask
    task t_fail;
        apb(1, 12'h08c, 32'h1);
        node.write_fail(48'habcd12345678, 16'hc0de);
        #1 chk({31'h0, irq}, 32'h1);
        apb(1, 12'h038, 32'h0);
        apb(0, 12'h038, 0);
        chk(rd, 32'h12345678);
        apb(0, 12'h03c, 0);
        chk(rd, 32'hc0deabcd);
    endtask
    task t_post;
        node.post_write(p);
        chk({31'h0, p}, 32'h0);
        apb(0, 12'h084, 0);
        chk({31'h0, rd[2]}, 32'h1);
        apb(1, 12'h080, 32'h00040000);
        node.post_write(p);
        chk({31'h0, p}, 32'h1);
    endtask
    task complete_run;
        $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_rom;
        t_fail;
        t_post;
        complete_run;
    end
    initial begin
        repeat (2000) @(posedge pclk);
        mismatches++;
        complete_run;
    end
endmodule // rom_map_posted_write_error_regs_bench
